// File: rtl/pbc_defs.svh
/*
 * Shared constants for the two-port gpio block with change detection:
 * register offsets, field positions and reset values.
 * Assumes it is included by bare name from rtl files; definitions only.
 */
// Summary of operation
// - option bit 7 low enables all port-b pull-ups
// - output pins never get a pull-up
// - pull-ups off after power-on reset
// - change detect only on inputs b7..b4
// - or of mismatches against latch sets flag
// - change flag can wake from sleep
// - port-b read or write reloads compare latch
// - persisting mismatch keeps setting the flag
// - b0 doubles as schmitt external interrupt input
// - program mode uses b6 clock, b7 data
// - port-b direction resets to all inputs
// - port c has six individually directed pins
// - enabled peripheral overrides port-c direction
// - port-c pins shared with timer1, pwm, serial
// - upper two port-c bits read zero
// - port-c direction resets to all ones
// - direction one floats pin, zero drives latch
// - data read gives pins, write sets latch
`ifndef PBC_DEFS_SVH
`define PBC_DEFS_SVH

// register indices; the byte address is four times the index
`define PBC_IDX_PORT_B_DATA    8'h06
`define PBC_IDX_PORT_C_DATA    8'h07
`define PBC_IDX_OPTION         8'h81
`define PBC_IDX_PORT_B_DIR     8'h86
`define PBC_IDX_PORT_C_DIR     8'h87
`define PBC_IDX_INT_CTRL       8'h0B
`define PBC_IDX_MODE_CTRL      8'h10

// field positions
`define PBC_OPT_PULLUP_DIS_N   7
`define PBC_INT_CHANGE_FLAG    0
`define PBC_INT_CHANGE_EN      3
`define PBC_MODE_SLEEP         0
`define PBC_MODE_PROG          1

// reset values
`define PBC_RST_OPTION         8'hFF
`define PBC_RST_PORT_B_DIR     8'hFF
`define PBC_RST_PORT_C_DIR     6'h3F

`endif

// File: rtl/pbc_pkg.sv
/*
 * Types shared by the gpio block.
 * Assumes pbc_defs.svh is compiled alongside.
 */
package pbc_pkg;

	// ahb-lite data-phase state of the register slave
	typedef enum logic [1:0] {
		PBC_IDLE,
		PBC_WRITE,
		PBC_READ
	} pbc_phase_t;

endpackage : pbc_pkg

// File: rtl/pbc_sync.sv
/*
 * Three-flop pin synchroniser: a change is accepted only when the
 * second and third stages agree. Assumes pins are asynchronous to clk.
 */
`timescale 1ns/1ns
module pbc_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// pin side
	input  wire logic [WIDTH-1:0] pin_async,
	// synchronised side
	output logic      [WIDTH-1:0] pin_sync
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// stage1 is read only by stage2, keeping metastability contained
	always_ff @(posedge clk) begin
		stage1 <= pin_async;
		stage2 <= stage1;
		stage3 <= stage2;
	end

	// per-bit agreement filter between stages two and three
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (srst) begin
					pin_sync[i] <= 1'b0;
				end else if (stage2[i] == stage3[i]) begin
					pin_sync[i] <= stage3[i];
				end
			end
		end
	endgenerate

endmodule : pbc_sync

// File: rtl/pbc_gpio.sv
/*
 * Port b / port c gpio with weak pull-up control, upper-nibble change
 * detection and peripheral direction override, behind an ahb-lite slave.
 * Assumes one ahb master, word transfers, pins resolved by the bench.
 */
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ns
`include "pbc_defs.svh"
module pbc_gpio
	import pbc_pkg::*;
#(
	parameter int PB_WIDTH = 8,
	parameter int PC_WIDTH = 6
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                srst,
	input  wire logic                por,
	// ahb-lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic      [31:0]         hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	// port b pins
	input  wire logic [PB_WIDTH-1:0] pb_in,
	output logic      [PB_WIDTH-1:0] pb_out,
	output logic      [PB_WIDTH-1:0] pb_oe,
	output logic      [PB_WIDTH-1:0] pb_pullup_en,
	// port b alternate functions
	output logic                     pb0_ext_int_pin,
	output logic                     pb6_prog_clock_pin,
	output logic                     pb7_prog_data_pin,
	output logic                     wake,
	output logic                     change_irq,
	// port c pins
	input  wire logic [PC_WIDTH-1:0] pc_in,
	output logic      [PC_WIDTH-1:0] pc_out,
	output logic      [PC_WIDTH-1:0] pc_oe,
	// port c peripheral override
	input  wire logic [PC_WIDTH-1:0] periph_en,
	input  wire logic [PC_WIDTH-1:0] periph_dir,
	input  wire logic [PC_WIDTH-1:0] periph_out,
	output logic      [PC_WIDTH-1:0] periph_in
);

	// software-visible state
	logic [7:0]          timer_pullup_option;
	logic [7:0]          port_b_direction;
	logic [5:0]          port_c_direction;
	logic [7:0]          port_b_latch;
	logic [5:0]          port_c_latch;
	logic                change_int_flag;
	logic                change_int_en;
	logic                sleep_mode;
	logic                prog_mode;
	logic [3:0]          compare_latch;

	// synchronised pins
	logic [PB_WIDTH-1:0] pb_sync;
	logic [PC_WIDTH-1:0] pc_sync;

	// ahb data-phase capture
	pbc_phase_t          phase;
	logic [7:0]          dp_index;

	// combinational helpers
	logic                addr_take;
	logic                wr_stb;
	logic                rd_stb;
	logic                pb_access;
	logic [3:0]          mismatch;
	logic [5:0]          pc_dir_eff;
	logic [31:0]         next_hrdata;
	logic [7:0]          wbyte;
	logic                wr_option;
	logic                wr_b_dir;
	logic                wr_c_dir;
	logic                wr_b_data;
	logic                wr_c_data;
	logic                wr_int_ctrl;
	logic                wr_mode_ctrl;

	// register byte address to printed index; misaligned or above the index range gives 8'hFF
	function automatic logic [7:0] reg_index(input logic [31:0] addr);
		logic [7:0] idx;
		idx = addr[9:2];
		if (addr[1:0] != 2'h0 || addr[31:10] != 22'h0) begin
			idx = 8'hFF;
		end
		return idx;
	endfunction : reg_index

	// one data-phase write aimed at a given register index; shared by
	// every register so all of them decode a write the same way
	function automatic logic write_hit(input pbc_phase_t ph,
	                                   input logic [7:0] cur,
	                                   input logic [7:0] idx);
		return (ph == PBC_WRITE) && (cur == idx);
	endfunction : write_hit

	// pins pass the three-flop filter before any logic sees them
	pbc_sync #(
		.WIDTH (PB_WIDTH)
	) u_sync_b (
		.clk       (clk),
		.srst      (srst),
		.pin_async (pb_in),
		.pin_sync  (pb_sync)
	);

	// port-c pins only feed reads and the peripheral inputs
	pbc_sync #(
		.WIDTH (PC_WIDTH)
	) u_sync_c (
		.clk       (clk),
		.srst      (srst),
		.pin_async (pc_in),
		.pin_sync  (pc_sync)
	);

	// address phase acceptance and data-phase strobes
	assign addr_take = hsel && hready && htrans[1];
	assign wr_stb    = (phase == PBC_WRITE);
	assign rd_stb    = (phase == PBC_READ);
	assign wbyte     = hwdata[7:0];
	assign pb_access = (wr_stb || rd_stb) &&
	                   (dp_index == `PBC_IDX_PORT_B_DATA);

	// per-register write strobes, all from the same data-phase decode
	assign wr_option    = write_hit(phase, dp_index, `PBC_IDX_OPTION);
	assign wr_b_dir     = write_hit(phase, dp_index, `PBC_IDX_PORT_B_DIR);
	assign wr_c_dir     = write_hit(phase, dp_index, `PBC_IDX_PORT_C_DIR);
	assign wr_b_data    = write_hit(phase, dp_index, `PBC_IDX_PORT_B_DATA);
	assign wr_c_data    = write_hit(phase, dp_index, `PBC_IDX_PORT_C_DATA);
	assign wr_int_ctrl  = write_hit(phase, dp_index, `PBC_IDX_INT_CTRL);
	assign wr_mode_ctrl = write_hit(phase, dp_index, `PBC_IDX_MODE_CTRL);

	// kind and index of the access, captured at the address edge
	always_ff @(posedge clk) begin
		if (srst) begin
			phase    <= PBC_IDLE;
			dp_index <= 8'h00;
		end else if (addr_take) begin
			phase    <= hwrite ? PBC_WRITE : PBC_READ;
			dp_index <= reg_index(haddr);
		end else begin
			phase    <= PBC_IDLE;
		end
	end

	// reads stall one cycle: hrdata must come from a flop, and loading
	// it in the data phase lets a read see a write made just before it;
	// writes never stall and the answer is always okay
	always_ff @(posedge clk) begin
		if (srst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= !(addr_take && !hwrite);
			hresp     <= 1'b0;
		end
	end

	// option register: bit 7 low turns the pull-ups on
	always_ff @(posedge clk) begin
		if (srst || por) begin
			timer_pullup_option <= `PBC_RST_OPTION;
		end else if (wr_option) begin
			timer_pullup_option <= wbyte;
		end
	end

	// direction registers come up as all inputs
	always_ff @(posedge clk) begin
		if (srst || por) begin
			port_b_direction <= `PBC_RST_PORT_B_DIR;
			port_c_direction <= `PBC_RST_PORT_C_DIR;
		end else begin
			if (wr_b_dir) begin
				port_b_direction <= wbyte;
			end
			if (wr_c_dir) begin
				port_c_direction <= wbyte[5:0];
			end
		end
	end

	// output latches keep their value over non-power resets
	always_ff @(posedge clk) begin
		if (por) begin
			port_b_latch <= 8'h00;
			port_c_latch <= 6'h00;
		end else begin
			if (wr_b_data) begin
				port_b_latch <= wbyte;
			end
			if (wr_c_data) begin
				port_c_latch <= wbyte[5:0];
			end
		end
	end

	// mode control and change-interrupt enable
	always_ff @(posedge clk) begin
		if (srst || por) begin
			sleep_mode    <= 1'b0;
			prog_mode     <= 1'b0;
			change_int_en <= 1'b0;
		end else begin
			if (wr_mode_ctrl) begin
				sleep_mode <= wbyte[`PBC_MODE_SLEEP];
				prog_mode  <= wbyte[`PBC_MODE_PROG];
			end else if (sleep_mode && change_int_flag) begin
				sleep_mode <= 1'b0;
			end
			if (wr_int_ctrl) begin
				change_int_en <= wbyte[`PBC_INT_CHANGE_EN];
			end
		end
	end

	// only upper input pins take part; outputs are masked out
	always_comb begin
		mismatch = (pb_sync[7:4] ^ compare_latch) &
		           port_b_direction[7:4];
	end

	// any port-b read or write reloads the compare latch
	always_ff @(posedge clk) begin
		if (srst || por) begin
			compare_latch <= 4'h0;
		end else if (pb_access) begin
			compare_latch <= pb_sync[7:4];
		end
	end

	// flag: set wins over clear, so a live mismatch re-sets it
	// limitation: any port-b poll ends the mismatch, so a key can be lost
	always_ff @(posedge clk) begin
		if (srst || por) begin
			change_int_flag <= 1'b0;
		end else if (|mismatch && !pb_access) begin
			change_int_flag <= 1'b1;
		end else if (wr_int_ctrl && !wbyte[`PBC_INT_CHANGE_FLAG]) begin
			change_int_flag <= 1'b0;
		end
	end

	// peripheral direction override for port c
	always_comb begin
		for (int i = 0; i < PC_WIDTH; i++) begin
			pc_dir_eff[i] = periph_en[i] ? periph_dir[i]
			                             : port_c_direction[i];
		end
	end

	// port-b drivers: direction one floats, zero drives the latch
	always_ff @(posedge clk) begin
		if (srst || por) begin
			pb_oe        <= 8'h00;
			pb_out       <= 8'h00;
			pb_pullup_en <= 8'h00;
		end else begin
			pb_oe        <= ~port_b_direction;
			pb_out       <= port_b_latch;
			// pull-up only on inputs, and only when enabled
			pb_pullup_en <= port_b_direction &
			    {8{~timer_pullup_option[`PBC_OPT_PULLUP_DIS_N]}};
		end
	end

	// port-c drivers: an enabled peripheral owns direction and level of
	// its pin while the software latch keeps its value underneath
	always_ff @(posedge clk) begin
		if (srst || por) begin
			pc_oe     <= 6'h00;
			pc_out    <= 6'h00;
			periph_in <= 6'h00;
		end else begin
			pc_oe     <= ~pc_dir_eff;
			for (int i = 0; i < PC_WIDTH; i++) begin
				pc_out[i] <= periph_en[i] ? periph_out[i]
				                          : port_c_latch[i];
			end
			periph_in <= pc_sync;
		end
	end

	// alternate port-b functions, taken from synchronised pins
	always_ff @(posedge clk) begin
		if (srst || por) begin
			pb0_ext_int_pin    <= 1'b0;
			pb6_prog_clock_pin <= 1'b0;
			pb7_prog_data_pin  <= 1'b0;
		end else begin
			pb0_ext_int_pin    <= pb_sync[0];
			pb6_prog_clock_pin <= prog_mode & pb_sync[6];
			pb7_prog_data_pin  <= prog_mode & pb_sync[7];
		end
	end

	// wake and interrupt follow the flag one edge later; wake is only a
	// short pulse because sleep ends on the same flag
	always_ff @(posedge clk) begin
		if (srst || por) begin
			wake       <= 1'b0;
			change_irq <= 1'b0;
		end else begin
			wake       <= sleep_mode & change_int_flag;
			change_irq <= change_int_en & change_int_flag;
		end
	end

	// read mux: data registers return the pin levels
	always_comb begin
		next_hrdata = 32'h0000_0000;
		unique case (dp_index)
			`PBC_IDX_PORT_B_DATA: next_hrdata[7:0] = pb_sync;
			`PBC_IDX_PORT_C_DATA: next_hrdata[5:0] = pc_sync;
			`PBC_IDX_OPTION:      next_hrdata[7:0] = timer_pullup_option;
			`PBC_IDX_PORT_B_DIR:  next_hrdata[7:0] = port_b_direction;
			// reads back the effective direction
			`PBC_IDX_PORT_C_DIR:  next_hrdata[5:0] = pc_dir_eff;
			`PBC_IDX_INT_CTRL: begin
				next_hrdata[`PBC_INT_CHANGE_FLAG] = change_int_flag;
				next_hrdata[`PBC_INT_CHANGE_EN]   = change_int_en;
			end
			`PBC_IDX_MODE_CTRL: begin
				next_hrdata[`PBC_MODE_SLEEP] = sleep_mode;
				next_hrdata[`PBC_MODE_PROG]  = prog_mode;
			end
			default:              next_hrdata = 32'h0000_0000;
		endcase
	end

	// read data is loaded at the end of the wait cycle and then held,
	// so it stands unchanged while hreadyout is high
	always_ff @(posedge clk) begin
		if (srst) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_stb) begin
			hrdata <= next_hrdata;
		end
	end

endmodule : pbc_gpio

// File: testbench/pbc_gpio_chk.sv
/*
 * Concurrent checks on the gpio block ports: bus answer, pull-ups,
 * reset directions, port-c override and pin synchronisation.
 * Assumes it is bound onto pbc_gpio and sees only its ports.
 */
`timescale 1ns/1ns
module pbc_gpio_chk #(
	parameter int PB_WIDTH = 8,
	parameter int PC_WIDTH = 6
) (
	// clock and resets
	input  wire logic                clk,
	input  wire logic                srst,
	input  wire logic                por,
	// bus
	input  wire logic                hsel,
	input  wire logic                hready,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [31:0]         hrdata,
	input  wire logic                hreadyout,
	input  wire logic                hresp,
	// pins
	input  wire logic [PB_WIDTH-1:0] pb_in,
	input  wire logic [PB_WIDTH-1:0] pb_oe,
	input  wire logic [PB_WIDTH-1:0] pb_pullup_en,
	input  wire logic                pb0_ext_int_pin,
	input  wire logic [PC_WIDTH-1:0] pc_oe,
	input  wire logic [PC_WIDTH-1:0] periph_en,
	input  wire logic [PC_WIDTH-1:0] periph_dir
);
	// one domain, so clock and disable are declared once
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst || por);

	property p_pullup_out;
		(pb_pullup_en & pb_oe) == '0;
	endproperty
	a_pullup_out: assert property (p_pullup_out)
		else $error("pull-up on a driven pin");
	property p_por_pullup;
		$fell(por) |-> pb_pullup_en == '0;
	endproperty
	a_por_pullup: assert property (p_por_pullup)
		else $error("pull-ups on after power-on reset");
	property p_rst_dir;
		$fell(srst) |-> pb_oe == '0 && pc_oe == '0;
	endproperty
	a_rst_dir: assert property (p_rst_dir)
		else $error("pins driven after reset");
	// never an error, and never two wait cycles in a row
	property p_bus_ok;
		!hresp && (hreadyout || $past(hreadyout));
	endproperty
	a_bus_ok: assert property (p_bus_ok)
		else $error("bus error or long wait seen");
	// a read takes exactly one wait cycle, a write none
	property p_rd_wait;
		hsel && hready && htrans[1] |=> hreadyout == $past(hwrite);
	endproperty
	a_rd_wait: assert property (p_rd_wait)
		else $error("read wait state not as expected");
	property p_rd_upper;
		hrdata[31:8] == '0;
	endproperty
	a_rd_upper: assert property (p_rd_upper)
		else $error("upper read bits not zero");
	// override lands one edge after the peripheral asks for it
	property p_override;
		periph_en != '0 |=> (pc_oe & $past(periph_en)) ==
			($past(periph_en) & ~$past(periph_dir));
	endproperty
	a_override: assert property (p_override)
		else $error("peripheral direction not applied");
	// port-b drivers only move three edges after a taken write
	property p_oe_write;
		$changed(pb_oe) && !$past(srst, 1) && !$past(por, 1) &&
			!$past(srst, 2) && !$past(por, 2)
			|-> $past(hsel, 3) && $past(htrans[1], 3) && $past(hwrite, 3);
	endproperty
	a_oe_write: assert property (p_oe_write)
		else $error("driver change without a write");
	property p_ext_int;
		$rose(pb0_ext_int_pin) |-> $past(pb_in[0], 3) ||
			$past(pb_in[0], 4) || $past(pb_in[0], 5);
	endproperty
	a_ext_int: assert property (p_ext_int)
		else $error("interrupt pin rose without the pin");
endmodule : pbc_gpio_chk

bind pbc_gpio pbc_gpio_chk #(.PB_WIDTH(PB_WIDTH), .PC_WIDTH(PC_WIDTH)) chk_u (
	.clk(clk), .srst(srst), .por(por), .hsel(hsel), .htrans(htrans),
	.hready(hready), .hwrite(hwrite), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp),
	.pb_in(pb_in), .pb_oe(pb_oe), .pb_pullup_en(pb_pullup_en),
	.pb0_ext_int_pin(pb0_ext_int_pin), .pc_oe(pc_oe),
	.periph_en(periph_en), .periph_dir(periph_dir));

// File: testbench/pbc_board.sv
/*
 * Board model: keys and weak pull-ups on port b, plain levels on port c.
 * Assumes the bench chooses which keys drive and at what level.
 */
`timescale 1ns/1ns
module pbc_board (
	// clock
	input  wire logic       clk,
	// port b side
	input  wire logic [7:0] pb_out,
	input  wire logic [7:0] pb_oe,
	input  wire logic [7:0] pb_pullup_en,
	input  wire logic [7:0] key_drv,
	input  wire logic [7:0] key_val,
	output logic      [7:0] pb_in,
	// port c side
	input  wire logic [5:0] pc_out,
	input  wire logic [5:0] pc_oe,
	input  wire logic [5:0] pc_ext,
	output logic      [5:0] pc_in
);
	logic float_lvl = 1'b0;

	// an open pin with no pull-up wanders, so it is never a stable guess
	always @(posedge clk) float_lvl <= ~float_lvl;
	// device drive wins, then keys (b0 also the interrupt line), then pull-up
	assign pb_in = (pb_oe & pb_out) | (~pb_oe & key_drv & key_val) |
		(~pb_oe & ~key_drv & (pb_pullup_en | {8{float_lvl}}));
	assign pc_in = (pc_oe & pc_out) | (~pc_oe & pc_ext);
endmodule : pbc_board

// File: testbench/test_port_b_c_gpio_with_change_int.sv
/*
 * Register-level tests of the gpio block through ahb-lite transfers.
 * Assumes one wait state on reads, none on writes, and the board model.
 */
`timescale 1ns/1ns
`include "pbc_defs.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
	error_cnt++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module test_port_b_c_gpio_with_change_int
	import pbc_pkg::*;
;
	logic        clk, srst, por, hsel, hwrite, woke;
	logic [31:0] haddr, hwdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  key_drv, key_val;
	logic [5:0]  pc_ext, periph_en, periph_dir, periph_out;
	wire  [31:0] hrdata;
	wire         hready, hreadyout, hresp, pb0_ext_int_pin;
	wire         pb6_prog_clock_pin, pb7_prog_data_pin, wake, change_irq;
	wire  [7:0]  pb_in, pb_out, pb_oe, pb_pullup_en;
	wire  [5:0]  pc_in, pc_out, pc_oe, periph_in;
	int          error_cnt = 0;
	int          compares = 0;

	assign hready = hreadyout;
	pbc_gpio #(.PB_WIDTH(8), .PC_WIDTH(6)) dut_u (.clk(clk), .srst(srst),
		.por(por), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
		.pb_pullup_en(pb_pullup_en), .pb0_ext_int_pin(pb0_ext_int_pin),
		.pb6_prog_clock_pin(pb6_prog_clock_pin),
		.pb7_prog_data_pin(pb7_prog_data_pin),
		.wake(wake), .change_irq(change_irq), .pc_in(pc_in),
		.pc_out(pc_out), .pc_oe(pc_oe), .periph_en(periph_en),
		.periph_dir(periph_dir), .periph_out(periph_out),
		.periph_in(periph_in));
	pbc_board board_u (.clk(clk), .pb_out(pb_out), .pb_oe(pb_oe),
		.pb_pullup_en(pb_pullup_en), .key_drv(key_drv), .key_val(key_val),
		.pb_in(pb_in), .pc_out(pc_out), .pc_oe(pc_oe), .pc_ext(pc_ext),
		.pc_in(pc_in));

	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// wake may be a short pulse since sleep ends itself, so remember it
	always @(posedge clk) if (wake === 1'b1) woke <= 1'b1;

	// one single word transfer; read data taken at the data-phase edge
	task automatic xfer(input logic wr, input logic [7:0] idx,
		input logic [7:0] wd);
		htrans <= 2'b10;
		hwrite <= wr;
		haddr  <= {22'h0, idx, 2'b00};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask : xfer
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] ex,
		input string nm);
		xfer(1'b0, idx, 8'h00);
		`CHK(nm, {24'h0, ex}, rd)
	endtask : rd_chk
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	task automatic print_verdict();
		if (error_cnt == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict

	// watchdog, far beyond the hundred or so cycles the tests need
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end

	// main sequence
	initial begin
		srst = 1'b1; por = 1'b1; hsel = 1'b1; hwrite = 1'b0; woke = 1'b0;
		haddr = 32'h0; hwdata = 32'h0; htrans = 2'b00; hsize = 3'b010;
		key_drv = 8'hFF; key_val = 8'h00; pc_ext = 6'h2A;
		periph_en = 6'h00; periph_dir = 6'h00; periph_out = 6'h00;
		wt(5);
		srst <= 1'b0;
		por <= 1'b0;
		rd_chk(`PBC_IDX_PORT_B_DIR, `PBC_RST_PORT_B_DIR, "pb_dir");
		rd_chk(`PBC_IDX_PORT_C_DIR, 8'h3F, "pc_dir");
		rd_chk(`PBC_IDX_OPTION, `PBC_RST_OPTION, "option");
		`CHK("pullup_por", 8'h00, pb_pullup_en)
		rd_chk(8'hFF, 8'h00, "unmapped");
		// pull-ups only on inputs, low nibble driven from the latch
		key_val <= 8'h01;
		xfer(1'b1, `PBC_IDX_OPTION, 8'h7F);
		xfer(1'b1, `PBC_IDX_PORT_B_DIR, 8'hF0);
		xfer(1'b1, `PBC_IDX_PORT_B_DATA, 8'hA5);
		wt(8);
		`CHK("pullup", 8'hF0, pb_pullup_en)
		`CHK("pb_oe", 8'h0F, pb_oe)
		`CHK("pb_out", 8'h05, (pb_out & pb_oe))
		`CHK("ext_int", 1'b1, pb0_ext_int_pin)
		rd_chk(`PBC_IDX_PORT_B_DATA, 8'h05, "pb_pins");
		// key on b4 during sleep; wait on change_irq, no polling of the port
		xfer(1'b1, `PBC_IDX_INT_CTRL, 8'h08);
		xfer(1'b1, `PBC_IDX_MODE_CTRL, 8'h01);
		key_val <= 8'h11;
		for (int i = 0; i < 20 && change_irq !== 1'b1; i++)
			@(posedge clk);
		`CHK("irq", 1'b1, change_irq)
		`CHK("wake", 1'b1, (woke | wake))
		rd_chk(`PBC_IDX_MODE_CTRL, 8'h00, "sleep_end");
		xfer(1'b1, `PBC_IDX_INT_CTRL, 8'h08);
		rd_chk(`PBC_IDX_INT_CTRL, 8'h09, "flag_held");
		rd_chk(`PBC_IDX_PORT_B_DATA, 8'h15, "pb_pins");
		xfer(1'b1, `PBC_IDX_INT_CTRL, 8'h08);
		rd_chk(`PBC_IDX_INT_CTRL, 8'h08, "flag_clr");
		wt(2);
		`CHK("irq_clr", 1'b0, change_irq)
		// b4 made an output: its own drop and the key are both ignored
		xfer(1'b1, `PBC_IDX_PORT_B_DIR, 8'hE0);
		key_val <= 8'h01;
		wt(12);
		`CHK("irq_out", 1'b0, change_irq)
		// programming mode hands b6 to the clock and b7 to the data line
		xfer(1'b1, `PBC_IDX_MODE_CTRL, 8'h02);
		key_val <= 8'hC1;
		wt(8);
		`CHK("prog_clk", 1'b1, pb6_prog_clock_pin)
		`CHK("prog_data", 1'b1, pb7_prog_data_pin)
		// peripherals force c0 out and c3 in over an all-output setting
		xfer(1'b1, `PBC_IDX_PORT_C_DIR, 8'h00);
		periph_en <= 6'h09;
		periph_dir <= 6'h08;
		periph_out <= 6'h01;
		wt(3);
		`CHK("pc_oe", 6'h37, pc_oe)
		`CHK("pc_out0", 1'b1, pc_out[0])
		rd_chk(`PBC_IDX_PORT_C_DIR, 8'h08, "pc_dir_eff");
		periph_en <= 6'h00;
		xfer(1'b1, `PBC_IDX_PORT_C_DIR, 8'hFF);
		rd_chk(`PBC_IDX_PORT_C_DIR, 8'h3F, "pc_dir_top");
		wt(6);
		rd_chk(`PBC_IDX_PORT_C_DATA, 8'h2A, "pc_pins");
		`CHK("periph_in", 6'h2A, periph_in)
		// a plain reset in mid-run restores every direction
		xfer(1'b1, `PBC_IDX_PORT_B_DIR, 8'h00);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		rd_chk(`PBC_IDX_PORT_B_DIR, 8'hFF, "pb_dir_srst");
		rd_chk(`PBC_IDX_PORT_C_DIR, 8'h3F, "pc_dir_srst");
		print_verdict();
	end
endmodule : test_port_b_c_gpio_with_change_int
